// >>> dv/sync_modem_model.sv
/*
  Behavioural modem partner: link clocks, receive bit stream and capture of sent bits.
  Assumes the bench drives Clear To Send, carrier and ring itself.
*/
`timescale 1ns/100ps
module sync_modem_model (
  output logic      txClk,
  output logic      rxClk,
  output logic      rxData,
  input  wire logic rts,
  input  wire logic txData
);
  bit txBits[$];

  // link lines idle with clocks still
  initial begin
    txClk = 1'b0;
    rxClk = 1'b0;
    rxData = 1'b1;
  end

  // transmit clock runs only while sending is requested; a bit is taken just before each rise
  always begin
    wait (rts === 1'b1);
    #100 txBits.push_back(txData);
    txClk = 1'b1;
    #100 txClk = 1'b0;
  end

  // sends bytes lsb first, then leaves the line at the inverse of its last bit
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      for (int k = 0; k < 8; k++) begin
        rxData = b[i][k];
        #100 rxClk = 1'b1;
        #100 rxClk = 1'b0;
      end
    end
    rxData = ~rxData;
  endtask : send
endmodule : sync_modem_model

// >>> dv/sync_serial_buffer_controller_tb.sv
/*
  Self-checking bench of the synchronous serial buffer controller.
  Assumes the modem model in dv/ and the design files in rtl/.
*/
`timescale 1ns/100ps
`include "sync_serial_defs.svh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin nFail++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module sync_serial_buffer_controller_tb;
  logic        clk, reset_n, hsel, hwrite, rdTake, cts, carrierDetect, ringIndicator, carrierStrap;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, expV, mskV, expQ[$], mskQ[$];
  wire         hready, hreadyout, txClk, rxClk, rxData, txData, rts, irqLevel6;
  wire  [31:0] hrdata;
  int          nFail = 0;
  int          compares = 0;
  integer      seed = 32'hc85c1d69;
  logic [7:0]  syncs[3] = '{8'h16, 8'h00, 8'hfe};

  assign hready = hreadyout;

  sync_serial_buffer_controller u_dut (.clk(clk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(), .txClk(txClk), .rxClk(rxClk), .rxData(rxData), .cts(cts),
    .carrierDetect(carrierDetect), .ringIndicator(ringIndicator), .carrierStrap(carrierStrap),
    .txData(txData), .rts(rts), .irqLevel6(irqLevel6));

  sync_modem_model u_modem (.txClk(txClk), .rxClk(rxClk), .rxData(rxData), .rts(rts), .txData(txData));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compares each read data phase against the oldest noted expectation
  always @(posedge clk) begin
    if (rdTake === 1'b1 && hreadyout === 1'b1) begin
      expV = expQ.pop_front();
      mskV = mskQ.pop_front();
      `CHK("hrdata", expV, hrdata & mskV)
    end
  end

  task automatic end_sim;
    if (nFail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // a wait that runs out counts as a mismatch and closes the run
  task automatic guard(input int n);
    if (n > 20000) begin
      nFail++;
      end_sim();
    end
  endtask : guard

  task automatic edgeRdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      guard(++n);
      @(posedge clk);
    end
  endtask : edgeRdy

  task automatic waitIrq;
    int n;
    n = 0;
    while (irqLevel6 !== 1'b1) begin
      guard(++n);
      @(posedge clk);
    end
  endtask : waitIrq

  // one single-word transfer; reads note the masked expectation
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, m);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {23'h0, a};
    edgeRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    rdTake <= ~w;
    if (!w) begin
      expQ.push_back(d & m);
      mskQ.push_back(m);
    end
    edgeRdy();
    rdTake <= 1'b0;
  endtask : bus

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] e, m);
    bus(1'b0, a, e, m);
  endtask : rd

  function automatic logic [8:0] bA(input int i);
    return 9'h100 + 9'(i * 4);
  endfunction : bA

  function automatic logic [7:0] ef(input logic [7:0] d);
    return {~^d[6:0], d[6:0]};
  endfunction : ef

  // searches the captured line bits for a byte sequence sent lsb first
  function automatic bit hasBits(input logic [7:0] b[$]);
    int n;
    bit ok;
    n = b.size() * 8;
    for (int s = 0; s + n <= u_modem.txBits.size(); s++) begin
      ok = 1'b1;
      for (int j = 0; j < n; j++) if (u_modem.txBits[s + j] !== b[j / 8][j % 8]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction : hasBits

  // loads a buffer, transmits it and checks where it stopped
  task automatic txRun(input logic f8, input int st, ta, ec, input logic [7:0] tc, input logic [7:0] b[$]);
    foreach (b[i]) wr(bA(st + i), {24'h0, b[i]});
    wr(`OFS_FLAG, f8 ? 32'h8 : 32'h0);
    wr(`OFS_START, 32'(st));
    wr(`OFS_TERM_ADDR, 32'(ta));
    wr(`OFS_TERM_CHAR, {24'h0, tc});
    u_modem.txBits.delete();
    wr(`OFS_CMD, {24'h0, `CMD_TRANSMIT});
    rd(`OFS_FLAG, 32'h0, 32'h80);
    `CHK("rts", 1'b1, rts)
    `CHK("irq", 1'b0, irqLevel6)
    waitIrq();
    `CHK("rts", 1'b0, rts)
    rd(`OFS_FLAG, 32'h80, 32'h80);
    rd(`OFS_CUR_ADDR, 32'(ec), 32'h3f);
  endtask : txRun

  // receives six characters after a preamble and two sync characters
  task automatic rxRun(input logic f8, cd, st, bad, stor, input logic [7:0] sy);
    logic [7:0] b[$], ex[$], d;
    b = {~sy, sy, sy};
    wr(`OFS_FLAG, f8 ? 32'h8 : 32'h0);
    wr(`OFS_SYNC_CHAR, {24'h0, sy});
    wr(`OFS_START, 32'd32);
    wr(`OFS_TERM_ADDR, 32'd37);
    for (int i = 0; i < 6; i++) wr(bA(32 + i), 32'h5a);
    carrierDetect <= cd;
    carrierStrap <= st;
    wr(`OFS_CMD, {24'h0, `CMD_RECEIVE});
    rd(`OFS_FLAG, 32'h0, 32'h80);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? {f8, 7'h7f} : 8'($random(seed));
      b.push_back(f8 ? d : ef(d) ^ {bad, 7'h0});
      ex.push_back(f8 ? d : {1'b0, d[6:0]});
    end
    u_modem.send(b);
    repeat (8) @(posedge clk);
    if (stor) waitIrq();
    foreach (ex[i]) rd(bA(32 + i), stor ? {24'h0, ex[i]} : 32'h5a, 32'hff);
    rd(`OFS_FLAG, {26'h0, bad, 5'h0}, 32'h20);
    if (!stor) wr(`OFS_CMD, {24'h0, `CMD_CLEAR});
  endtask : rxRun

  // main sequence
  initial begin
    logic [7:0] d0, d1, t;
    bit ones;
    hsel = 1'b0;
    hwrite = 1'b0;
    rdTake = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    reset_n = 1'b0;
    cts = 1'b1;
    carrierDetect = 1'b1;
    ringIndicator = 1'b0;
    carrierStrap = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("rts", 1'b0, rts)
    `CHK("irq", 1'b1, irqLevel6)
    rd(`OFS_FLAG, 32'h80, 32'ha1);
    ringIndicator <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`OFS_FLAG, 32'h1, 32'h1);
    ringIndicator <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`OFS_FLAG, 32'h0, 32'h1);
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    while (d0 == 8'h17) d0 = 8'($random(seed));
    while (d1 == 8'h17) d1 = 8'($random(seed));
    txRun(1'b1, 0, 5, 5, 8'h17, {8'h16, 8'h16, d0, d1, 8'h5a, 8'h5a});
    `CHK("txFrame8", 1'b1, hasBits({8'h16, 8'h16, d0, d1}))
    txRun(1'b0, 0, 63, 5, 8'h17, {8'h16, 8'h16, d0, d1, 8'h5a, 8'h17});
    `CHK("txFrame7", 1'b1, hasBits({8'h16, 8'h16, ef(d0), ef(d1)}))
    for (int i = 0; i < 12; i++) begin
      t = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      txRun(1'b1, 10, 63, 11, t, {~t, t, ~t});
    end
    cts <= 1'b0;
    u_modem.txBits.delete();
    wr(`OFS_CMD, {24'h0, `CMD_TRANSMIT});
    for (int n = 0; u_modem.txBits.size() < 40; n++) begin
      guard(n);
      @(posedge clk);
    end
    ones = 1'b1;
    // the first sample still shows the last bit of the previous frame
    for (int i = 1; i < u_modem.txBits.size(); i++) ones &= u_modem.txBits[i];
    `CHK("marks", 1'b1, ones)
    rd(`OFS_CUR_ADDR, 32'd11, 32'h3f);
    wr(`OFS_CMD, {24'h0, `CMD_CLEAR});
    rd(`OFS_FLAG, 32'h80, 32'h80);
    `CHK("rts", 1'b0, rts)
    cts <= 1'b1;
    foreach (syncs[i]) rxRun(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, syncs[i]);
    rxRun(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h16);
    rxRun(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'h16);
    rxRun(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h16);
    rxRun(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h16);
    wr(`OFS_CMD, {24'h0, `CMD_CLEAR});
    rd(`OFS_FLAG, 32'h80, 32'ha0);
    rxRun(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h16);
    cts <= 1'b0;
    wr(`OFS_CMD, {24'h0, `CMD_TRANSMIT});
    reset_n <= 1'b0;
    @(posedge clk);
    `CHK("rts", 1'b0, rts)
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`OFS_FLAG, 32'h80, 32'ha0);
    end_sim();
  end
endmodule : sync_serial_buffer_controller_tb

// >>> rtl/sync_serial_buffer_controller.sv
/*
  Synchronous serial buffer controller: AHB-Lite register slave, 64-byte
  buffer, USRT transmitter and sync-hunting receiver.
  Assumes link clocks far slower than clk; all link pins are asynchronous.
*/
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "sync_serial_defs.svh"
module sync_serial_buffer_controller import sync_serial_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        txClk,
  input  wire logic        rxClk,
  input  wire logic        rxData,
  input  wire logic        cts,
  input  wire logic        carrierDetect,
  input  wire logic        ringIndicator,
  input  wire logic        carrierStrap,
  output logic             txData,
  output logic             rts,
  output logic             irqLevel6
);
  logic [7:0]  mem [0:63];
  logic [6:0]  metaReg, syncReg;
  logic        txClkPrev, rxClkPrev;
  logic        dWrReg;
  logic [8:0]  dAddrReg;
  logic [31:0] hrdataReg;
  logic        notBusyReg, rtsReg, charErrReg, ringReg, fmt8Reg;
  logic [5:0]  startReg, termAddrReg, curAddrReg;
  logic [7:0]  termCharReg, syncCharReg;
  tx_state_t   txStateReg;
  rx_state_t   rxStateReg;
  logic [7:0]  txShiftReg, rxShiftReg;
  logic [2:0]  txBitReg, rxBitReg;
  logic        txDataReg;
  logic [1:0]  syncCntReg;

  // address decode shared by read and write paths
  function automatic reg_sel_t selFor(input logic [8:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[8]) s = SEL_BUF;
    else if (a == `OFS_FLAG) s = SEL_FLAG;
    else if (a == `OFS_CMD) s = SEL_CMD;
    else if (a == `OFS_START) s = SEL_START;
    else if (a == `OFS_TERM_ADDR) s = SEL_TERMA;
    else if (a == `OFS_TERM_CHAR) s = SEL_TERMC;
    else if (a == `OFS_SYNC_CHAR) s = SEL_SYNC;
    else if (a == `OFS_CUR_ADDR) s = SEL_CUR;
    return s;
  endfunction : selFor

  // line frame of a buffer byte: odd parity over bits 6..0, or all 8 bits
  function automatic logic [7:0] frameOf(input logic [7:0] b, input logic f8);
    return f8 ? b : {~^b[6:0], b[6:0]};
  endfunction : frameOf

  // two-stage synchronisers for every link pin, then edge detect on stage two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      metaReg   <= 7'h00;
      syncReg   <= 7'h00;
      txClkPrev <= 1'b0;
      rxClkPrev <= 1'b0;
    end else if (ce) begin
      metaReg   <= {txClk, rxClk, rxData, cts, carrierDetect, ringIndicator, carrierStrap};
      syncReg   <= metaReg;
      txClkPrev <= syncReg[6];
      rxClkPrev <= syncReg[5];
    end
  end

  logic txEdge, rxEdge, rxBit, ctsSync, carrierOk, ringSync;
  assign txEdge    = ce & syncReg[6] & ~txClkPrev; // [R23]
  assign rxEdge    = ce & syncReg[5] & ~rxClkPrev; // [R23]
  assign rxBit     = syncReg[4];
  assign ctsSync   = syncReg[3];
  assign carrierOk = syncReg[2] | syncReg[0];      // [R13]
  assign ringSync  = syncReg[1];

  // bus decode
  logic     addrPhase, wrFlag, wrCmd, wrBuf;
  reg_sel_t aSel, dSel;
  logic [7:0] cmdVal;
  assign addrPhase = ce & hsel & hready & htrans[1];
  assign aSel      = selFor(haddr[8:0]);
  assign dSel      = selFor(dAddrReg);
  assign cmdVal    = hwdata[7:0];
  assign wrFlag    = dWrReg && dSel == SEL_FLAG;
  assign wrCmd     = dWrReg && dSel == SEL_CMD;
  assign wrBuf     = dWrReg && dSel == SEL_BUF;

  logic txStart, rxStart, devClr;
  assign txStart = wrCmd && cmdVal == `CMD_TRANSMIT;
  assign rxStart = wrCmd && cmdVal == `CMD_RECEIVE;
  assign devClr  = wrCmd && cmdVal == `CMD_CLEAR;

  // read value, taken in the address phase so hrdata is a flop
  logic [7:0]  flagByte;
  logic [31:0] readValue;
  assign flagByte = {notBusyReg, 1'b0, charErrReg, 1'b0, fmt8Reg, 2'b00, ringReg};
  always_comb begin
    readValue = 32'h0000_0000;
    case (aSel)
      SEL_FLAG:  readValue[7:0] = flagByte;
      SEL_START: readValue[5:0] = startReg;
      SEL_TERMA: readValue[5:0] = termAddrReg;
      SEL_TERMC: readValue[7:0] = termCharReg;
      SEL_SYNC:  readValue[7:0] = syncCharReg;
      SEL_CUR:   readValue[5:0] = curAddrReg;
      SEL_BUF:   readValue[7:0] = mem[haddr[7:2]];
      default:   readValue = 32'h0000_0000;
    endcase
  end

  // bus phase registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dWrReg    <= 1'b0;
      dAddrReg  <= 9'h000;
      hrdataReg <= 32'h0000_0000;
    end else if (ce) begin
      dWrReg   <= addrPhase & hwrite;
      dAddrReg <= haddr[8:0];
      if (addrPhase && !hwrite) hrdataReg <= readValue;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdataReg;

  // software configuration registers; flag write port holds the format bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt8Reg     <= 1'b0;
      startReg    <= `ADDR_RST;
      termAddrReg <= `ADDR_RST;
      termCharReg <= `TERM_CHAR_RST;
      syncCharReg <= `SYNC_RST;
    end else if (ce && dWrReg) begin
      if (wrFlag) fmt8Reg <= hwdata[`BIT_FMT8];
      if (dSel == SEL_START) startReg <= hwdata[5:0];
      if (dSel == SEL_TERMA) termAddrReg <= hwdata[5:0];
      if (dSel == SEL_TERMC) termCharReg <= hwdata[7:0];
      if (dSel == SEL_SYNC) syncCharReg <= hwdata[7:0];
    end
  end

  // transmit side: fetch decision at each character boundary
  logic [7:0] fetchByte, rxWin, rxByte;
  logic charLoad, fetch, termHit, txAdv, txGo, txDone;
  assign fetchByte = mem[curAddrReg];
  assign charLoad  = txEdge && txBitReg == `LAST_BIT;
  assign fetch     = charLoad && txStateReg == TX_RUN && ctsSync;      // [R10]
  assign termHit   = fetchByte == termCharReg;                          // [R5]
  assign txGo      = ce && txStateReg == TX_WAIT && ctsSync;            // [R21]
  assign txDone    = fetch && (termHit || curAddrReg == termAddrReg);   // [R1] [R22]
  assign txAdv     = fetch && !txDone;                                  // [R21]

  // transmit shifter, LSB first, marks whenever nothing is fetched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txShiftReg <= `MARK_CHAR;
      txBitReg   <= 3'd0;
      txDataReg  <= 1'b1;
    end else if (txEdge) begin
      txDataReg <= txShiftReg[0];
      txBitReg  <= txBitReg + 3'd1;
      if (charLoad)
        txShiftReg <= (fetch && !termHit) ? frameOf(fetchByte, fmt8Reg) : `MARK_CHAR; // [R7] [R8] [R10]
      else
        txShiftReg <= {1'b1, txShiftReg[7:1]};
    end
  end
  assign txData = txDataReg;

  // transmit state and request to send
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txStateReg <= TX_IDLE;
      rtsReg     <= 1'b0;                                       // [R22]
    end else if (ce) begin
      if (devClr || txDone || rxStart) begin
        txStateReg <= TX_IDLE;
        rtsReg     <= 1'b0;                                     // [R1] [R22]
      end else if (txStart) begin
        txStateReg <= TX_WAIT;
        rtsReg     <= 1'b1;                                     // [R21]
      end else if (txGo) begin
        txStateReg <= TX_RUN;
      end
    end
  end
  assign rts = rtsReg;

  // receive side: sliding window, character boundary after sync
  logic charDone, syncHit, rxStore, rxDone, rxAdv, parityBad;
  assign rxWin     = {rxBit, rxShiftReg[7:1]};
  assign syncHit   = rxWin == syncCharReg;                           // [R14]
  assign charDone  = rxEdge && rxBitReg == `LAST_BIT;
  assign rxStore   = charDone && rxStateReg == RX_DATA && carrierOk; // [R11] [R15]
  assign rxByte    = fmt8Reg ? rxWin : {1'b0, rxWin[6:0]};           // [R16] [R17] [R20]
  assign parityBad = !fmt8Reg && !(^rxWin);                          // [R18]
  assign rxDone    = rxStore && curAddrReg == termAddrReg;
  assign rxAdv     = rxStore && !rxDone;

  // receive shifter and acquisition state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxShiftReg <= 8'h00;
      rxBitReg   <= 3'd0;
      syncCntReg <= 2'd0;
      rxStateReg <= RX_IDLE;
    end else if (ce) begin
      if (rxEdge) begin
        rxShiftReg <= rxWin;
        rxBitReg   <= rxBitReg + 3'd1;
      end
      if (devClr || rxDone || txStart) begin
        rxStateReg <= RX_IDLE;
      end else if (rxStart) begin
        rxStateReg <= RX_HUNT;
        syncCntReg <= 2'd0;
      end else if (rxEdge) begin
        case (rxStateReg)
          RX_HUNT: if (syncHit) begin                 // bit-by-bit hunt aligns the frame
            rxStateReg <= RX_SYNC;
            syncCntReg <= 2'd1;
            rxBitReg   <= 3'd0;
          end
          RX_SYNC: if (charDone) begin
            if (!syncHit) rxStateReg <= RX_HUNT;
            else if (syncCntReg + 2'd1 == `SYNC_NEEDED) rxStateReg <= RX_DATA; // [R14] [R15]
            else syncCntReg <= syncCntReg + 2'd1;
          end
          default: rxStateReg <= rxStateReg;
        endcase
      end
    end
  end

  // shared status: not busy, character error, ring, current address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      notBusyReg <= 1'b1;                                         // [R22]
      charErrReg <= 1'b0;                                         // [R19]
      ringReg    <= 1'b0;                                         // [R4]
      curAddrReg <= `ADDR_RST;
    end else if (ce) begin
      ringReg <= ringSync;                                        // [R3]
      if (devClr || txDone || rxDone) notBusyReg <= 1'b1;         // [R1] [R22]
      else if (txStart || rxStart) notBusyReg <= 1'b0;            // [R12] [R21]
      if (rxStore && parityBad) charErrReg <= 1'b1;               // [R18]
      else if (devClr) charErrReg <= 1'b0;                        // [R19]
      if (txGo || rxStart) curAddrReg <= startReg;                // [R6]
      else if (txAdv || rxAdv) curAddrReg <= curAddrReg + 6'd1;   // [R5] [R6]
    end
  end
  assign irqLevel6 = notBusyReg;                                  // [R2]

  // buffer memory: receiver store wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wrBuf) mem[dAddrReg[7:2]] <= hwdata[7:0];
      if (rxStore) mem[curAddrReg] <= rxByte;                     // [R16] [R20]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_irq_level: assert property (irqLevel6 == notBusyReg && (notBusyReg || rtsReg || rxStateReg != RX_IDLE
                                 || txStateReg != TX_IDLE || $past(notBusyReg)))   // [R2]
    else $error("interrupt level does not follow not-busy");
  a_done_drops_rts: assert property (txDone |=> notBusyReg && !rtsReg)              // [R1]
    else $error("end of transmit left rts high or busy");
  a_term_holds_addr: assert property (fetch && termHit |=> $stable(curAddrReg))      // [R5]
    else $error("current address moved past terminating character");
  a_tx_start: assert property (txStart && !devClr && !txDone |=> !notBusyReg && rtsReg && txStateReg == TX_WAIT) // [R21]
    else $error("transmit command did not raise rts");
  a_load_start: assert property (txGo |=> curAddrReg == $past(startReg))            // [R6]
    else $error("current address not loaded from start");
  a_cts_marks: assert property (charLoad && !ctsSync |=> txShiftReg == `MARK_CHAR)  // [R10]
    else $error("character fetched while cts low");
  a_tx_parity: assert property (fetch && !termHit && !fmt8Reg |=> ^txShiftReg == 1'b1) // [R7]
    else $error("seven-bit frame lacks odd parity");
  a_tx_eight: assert property (fetch && !termHit && fmt8Reg |=> txShiftReg == $past(fetchByte)) // [R8]
    else $error("eight-bit frame altered");
  a_store_carrier: assert property (rxStore |-> carrierOk && rxStateReg == RX_DATA) // [R11]
    else $error("character stored without carrier or before sync");
  a_rx_busy: assert property (rxStart && !devClr && !txDone |=> !notBusyReg)         // [R12]
    else $error("receive command left not-busy set");
  a_char_err: assert property (rxStore && parityBad |=> charErrReg)                  // [R18]
    else $error("parity error not flagged");
  a_clear_err: assert property (devClr && !(rxStore && parityBad) |=> !charErrReg && notBusyReg) // [R19]
    else $error("device clear left error or busy");
  a_ring_follow: assert property (ce |=> ringReg == $past(ringSync))                 // [R3]
    else $error("ring flag does not follow ring indicator");

  c_tx_done:  cover property (txDone && termHit);
  c_rx_store: cover property (rxStore && fmt8Reg);
  c_err_set:  cover property ($rose(charErrReg));
endmodule : sync_serial_buffer_controller

// >>> rtl/sync_serial_defs.svh
/*
  Offsets, field positions, command codes and reset values of the
  synchronous serial buffer controller.
  Assumes inclusion by bare name from rtl/.
*/
// How it works
// R1: stopping on the terminating character sets not-busy (bit 7) and drops RTS.
// R2: interrupt level 6 is requested exactly while not-busy is set.
// R3: ring flag (bit 0) follows Ring Indicator, set and clear.
// R4: after init or device clear with ring low, ring flag reads clear.
// R5: the terminating character ends transmission; current address stays on that character.
// R6: transmit starts at buffer start; current address shows the stop position.
// R7: seven-bit format sends data bits 6..0 plus odd parity.
// R8: eight-bit format sends data bits 7..0 unchanged.
// R9: software puts two SYN characters at the head of the transmit buffer.
// R10: with Clear To Send low, no fetch; mark characters go out instead.
// R11: received characters are stored only while carrier is present.
// R12: the receive command clears not-busy for the whole reception.
// R13: carrier strap fitted means carrier is always present.
// R14: reception begins after two consecutive sync matches; any sync value works.
// R15: sync characters used for alignment never enter the buffer.
// R16: eight-bit receive stores every byte exactly as received.
// R17: in eight-bit receive an ordinary byte is stored as plain data.
// R18: a parity error while receiving sets character error (bit 5).
// R19: init or device clear alone clears character error.
// R20: seven-bit odd-parity receive captures every value 00..7f.
// R21: transmit clears not-busy, raises RTS, waits CTS, loads start, steps.
// R22: init, device clear and terminating address set not-busy and drop RTS.
// R23: link clocks are sampled and edge-detected in the host clock domain.
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH
`define OFS_FLAG       9'h000
`define OFS_CMD        9'h008
`define OFS_START      9'h00c
`define OFS_TERM_ADDR  9'h010
`define OFS_TERM_CHAR  9'h014
`define OFS_SYNC_CHAR  9'h018
`define OFS_CUR_ADDR   9'h01c
`define BIT_NOT_BUSY   7
`define BIT_CHAR_ERR   5
`define BIT_FMT8       3
`define BIT_RING       0
`define CMD_CLEAR      8'h01
`define CMD_RECEIVE    8'h02
`define CMD_TRANSMIT   8'h03
`define MARK_CHAR      8'hff
`define SYNC_RST       8'h16
`define TERM_CHAR_RST  8'h00
`define ADDR_RST       6'h00
`define SYNC_NEEDED    2'd2
`define LAST_BIT       3'd7
`endif

// >>> rtl/sync_serial_pkg.sv
/*
  Types of the synchronous serial buffer controller.
  Assumes nothing of its surroundings.
*/
package sync_serial_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_RUN = 2'b10} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_HUNT = 2'b01, RX_SYNC = 2'b10, RX_DATA = 2'b11} rx_state_t;
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000, SEL_FLAG = 4'b0001, SEL_CMD = 4'b0010, SEL_START = 4'b0011,
    SEL_TERMA = 4'b0100, SEL_TERMC = 4'b0101, SEL_SYNC = 4'b0110, SEL_CUR = 4'b0111,
    SEL_BUF = 4'b1000
  } reg_sel_t;
endpackage : sync_serial_pkg
